// ### rtl/xcvr_cfg_pkg.sv
// Shared types and constants for the receive framer, parity and clock select logic.
// Assumes all inputs are synchronous to sys_clk and slower rates arrive as enable pulses.
package xcvr_cfg_pkg;

	// Three-level static select, encoded as two bits on a plain port.
	typedef enum logic [1:0] {
		LVL_LOW = 2'b00,
		LVL_MID = 2'b01,
		LVL_HIGH = 2'b10
	} tri_level_t;

	localparam int CHAR_W = 10;
	localparam int NUM_CH = 2;

	// Code group K28.5 in both running-disparity forms, first serial bit in bit 9.
	localparam logic [9:0] K285_RD_NEG = 10'h0fa;
	localparam logic [9:0] K285_RD_POS = 10'h305;
	// The 8-bit comma is the leading eight bits of K28.5.
	localparam logic [7:0] COMMA_RD_NEG = 8'h3e;
	localparam logic [7:0] COMMA_RD_POS = 8'hc1;

	// Pair of symbols must fit inside this many bits for the mid-level framer.
	localparam int MID_SPAN_BITS = 50;
	localparam logic [2:0] MID_SPAN_CHARS = 3'((MID_SPAN_BITS / CHAR_W) - 1);
	// Consecutive characters needed by the high-level framer.
	localparam logic [2:0] HIGH_RUN_CHARS = 3'h4;

	localparam logic [3:0] OFFSET_RST = 4'h0;
	localparam logic [2:0] COUNT_RST = 3'h0;

	typedef struct packed {
		logic [1:0] char_type;
		logic [7:0] data;
		logic odd_parity;
	} tx_word_t;

	typedef struct packed {
		logic [2:0] status;
		logic [7:0] data;
	} rx_word_t;

	function automatic logic symbol_match(input logic [9:0] w, input tri_level_t sel);
		if (sel == LVL_HIGH) begin
			symbol_match = (w == K285_RD_NEG) || (w == K285_RD_POS);
		end else begin
			symbol_match = (w[9:2] == COMMA_RD_NEG) || (w[9:2] == COMMA_RD_POS);
		end
	endfunction

endpackage

// ### rtl/char_framer.sv
// One channel's character framer: finds the framing symbol at any bit offset and aligns.
// Assumes ten new serial bits arrive per bits_valid pulse, first bit in bit 9.
`timescale 1ns/1ps
module char_framer
	import xcvr_cfg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic bits_valid,
	input wire logic [9:0] bits_in,
	input wire logic reframe_allow,
	input wire tri_level_t framer_style_select,
	input wire tri_level_t frame_symbol_select,
	output logic [9:0] char_out,
	output logic char_valid
);

	logic [19:0] hist_r, hist_nxt;
	logic [3:0] offset_r, offset_nxt;
	logic [3:0] cand_r, cand_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic [2:0] age_r, age_nxt;
	logic stretch_r, stretch_nxt;
	logic [9:0] char_r, char_nxt;
	logic valid_r, valid_nxt;
	logic [9:0] det;
	logic any_det;
	logic [3:0] first_k;
	logic [19:0] hnew;

	always_comb begin
		hnew = {hist_r[9:0], bits_in};
		det = '0;
		any_det = 1'b0;
		first_k = OFFSET_RST;
		for (int k = 9; k >= 0; k--) begin
			det[k] = symbol_match(hnew[19 - k -: 10], frame_symbol_select);
			if (det[k]) begin
				any_det = 1'b1;
				first_k = 4'(k);
			end
		end
	end

	always_comb begin
		hist_nxt = hist_r;
		offset_nxt = offset_r;
		cand_nxt = cand_r;
		cnt_nxt = cnt_r;
		age_nxt = age_r;
		stretch_nxt = 1'b0;
		char_nxt = char_r;
		valid_nxt = 1'b0;
		if (bits_valid) begin
			hist_nxt = hnew;
			char_nxt = hnew[19 - offset_r -: 10];
			// A stretched cycle withholds one character so the clock lines up with the data.
			valid_nxt = ~stretch_r;
			if (age_r != 3'h7) begin
				age_nxt = age_r + 3'h1;
			end
			unique case (framer_style_select)
				LVL_LOW: begin
					if (reframe_allow && any_det && first_k != offset_r) begin
						offset_nxt = first_k;
						stretch_nxt = 1'b1;
					end
				end
				LVL_MID: begin
					if (cnt_r != COUNT_RST && det[cand_r] && age_r < MID_SPAN_CHARS) begin
						if (reframe_allow) begin
							offset_nxt = cand_r;
						end
						cnt_nxt = COUNT_RST;
					end else if (any_det) begin
						cand_nxt = first_k;
						cnt_nxt = 3'h1;
						age_nxt = COUNT_RST;
					end
				end
				LVL_HIGH: begin
					if (cnt_r != COUNT_RST && det[cand_r]) begin
						cnt_nxt = cnt_r + 3'h1;
						if (cnt_r + 3'h1 == HIGH_RUN_CHARS) begin
							if (reframe_allow) begin
								offset_nxt = cand_r;
							end
							cnt_nxt = COUNT_RST;
						end
					end else if (any_det) begin
						cand_nxt = first_k;
						cnt_nxt = 3'h1;
					end else begin
						cnt_nxt = COUNT_RST;
					end
				end
				default: begin
					cnt_nxt = COUNT_RST;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hist_r <= '0;
			offset_r <= OFFSET_RST;
			cand_r <= OFFSET_RST;
			cnt_r <= COUNT_RST;
			age_r <= COUNT_RST;
			stretch_r <= 1'b0;
			char_r <= '0;
			valid_r <= 1'b0;
		end else begin
			hist_r <= hist_nxt;
			offset_r <= offset_nxt;
			cand_r <= cand_nxt;
			cnt_r <= cnt_nxt;
			age_r <= age_nxt;
			stretch_r <= stretch_nxt;
			char_r <= char_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign char_out = char_r;
	assign char_valid = valid_r;

endmodule

// ### rtl/rx_framer_parity_clock_select.sv
// Two-channel framing, rate compensation, parity check/generate and clock source selection.
// Assumes all inputs synchronous to sys_clk; reference and transmit clocks arrive as enable pulses.
`timescale 1ns/1ps
module rx_framer_parity_clock_select
	import xcvr_cfg_pkg::*;
#(
	parameter int CHANNELS = NUM_CH
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reframe_allow,
	input wire tri_level_t framer_style_select,
	input wire tri_level_t frame_symbol_select,
	input wire tri_level_t parity_control,
	input wire tri_level_t tx_operating_select,
	input wire tri_level_t decoder_select,
	input wire tri_level_t tx_clock_source_select,
	input wire tri_level_t rx_clock_source_select,
	input wire logic reference_clock,
	input wire logic ref_tick,
	input wire logic tx_clk_tick,
	input wire tx_word_t [CHANNELS-1:0] tx_word_in,
	output tx_word_t [CHANNELS-1:0] tx_word_captured,
	output logic [CHANNELS-1:0] tx_parity_error,
	input wire logic [CHANNELS-1:0] rx_bits_valid,
	input wire logic [CHANNELS-1:0][9:0] rx_bits_in,
	output logic [CHANNELS-1:0][9:0] rx_aligned_char,
	output logic [CHANNELS-1:0] rx_aligned_valid,
	input wire logic [CHANNELS-1:0] comp_insert_req,
	input wire logic [CHANNELS-1:0] comp_delete_req,
	input wire logic [CHANNELS-1:0] rx_word_valid,
	input wire rx_word_t [CHANNELS-1:0] rx_word_in,
	output rx_word_t [CHANNELS-1:0] rx_word_out,
	output logic [CHANNELS-1:0] rx_odd_parity_out,
	output logic [CHANNELS-1:0] rx_odd_parity_oe,
	output logic delayed_reference_out,
	output logic delayed_reference_oe
);

	logic bypassed;
	logic tx_capture_en;
	logic rx_on_ref;
	logic dref_r, dref_nxt;

	// With parity_control at LVL_MID, mixed encoder/decoder settings fall back to the eight-bit coverage.
	assign bypassed = (tx_operating_select == LVL_LOW) && (decoder_select == LVL_LOW);
	assign tx_capture_en = (tx_clock_source_select == LVL_LOW) ? ref_tick : tx_clk_tick;
	assign rx_on_ref = (rx_clock_source_select == LVL_LOW);

	always_comb begin
		dref_nxt = reference_clock;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dref_r <= 1'b0;
		end else begin
			dref_r <= dref_nxt;
		end
	end

	assign delayed_reference_out = dref_r;
	assign delayed_reference_oe = rx_on_ref;

	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
		logic [9:0] fr_char;
		logic fr_valid;
		logic fr_is_sym;
		logic [9:0] eb_char_r, eb_char_nxt;
		logic eb_valid_r, eb_valid_nxt;
		logic [9:0] hold_r, hold_nxt;
		logic hold_full_r, hold_full_nxt;
		logic ins_pend_r, ins_pend_nxt;
		logic del_pend_r, del_pend_nxt;
		logic insert_now_r, insert_now_nxt;
		tx_word_t txw_r, txw_nxt;
		logic txerr_r, txerr_nxt;
		rx_word_t rxw_r, rxw_nxt;
		logic rxpar_r, rxpar_nxt;
		logic tx_ones, rx_ones;

		char_framer u_framer (
			.sys_clk(sys_clk),
			.rst(rst),
			.bits_valid(rx_bits_valid[c]),
			.bits_in(rx_bits_in[c]),
			.reframe_allow(reframe_allow),
			.framer_style_select(framer_style_select),
			.frame_symbol_select(frame_symbol_select),
			.char_out(fr_char),
			.char_valid(fr_valid)
		);

		assign fr_is_sym = symbol_match(fr_char, frame_symbol_select);

		// Rate compensation. A one-entry hold parks the character displaced by an insert.
		always_comb begin
			eb_char_nxt = eb_char_r;
			eb_valid_nxt = 1'b0;
			hold_nxt = hold_r;
			hold_full_nxt = hold_full_r;
			ins_pend_nxt = ins_pend_r | comp_insert_req[c];
			del_pend_nxt = del_pend_r | comp_delete_req[c];
			insert_now_nxt = 1'b0;
			if (!rx_on_ref) begin
				eb_char_nxt = fr_char;
				eb_valid_nxt = fr_valid;
				ins_pend_nxt = 1'b0;
				del_pend_nxt = 1'b0;
				hold_full_nxt = 1'b0;
			end else if (insert_now_r) begin
				eb_char_nxt = K285_RD_NEG;
				eb_valid_nxt = 1'b1;
				if (fr_valid) begin
					hold_nxt = fr_char;
					hold_full_nxt = 1'b1;
				end
			end else if (hold_full_r) begin
				eb_char_nxt = hold_r;
				eb_valid_nxt = 1'b1;
				if (fr_valid && del_pend_r && fr_is_sym) begin
					hold_full_nxt = 1'b0;
					del_pend_nxt = comp_delete_req[c];
				end else if (fr_valid) begin
					hold_nxt = fr_char;
				end else begin
					hold_full_nxt = 1'b0;
				end
			end else if (fr_valid) begin
				if (del_pend_r && fr_is_sym) begin
					del_pend_nxt = comp_delete_req[c];
				end else begin
					eb_char_nxt = fr_char;
					eb_valid_nxt = 1'b1;
					if (ins_pend_r && fr_is_sym) begin
						insert_now_nxt = 1'b1;
						ins_pend_nxt = comp_insert_req[c];
					end
				end
			end
		end

		// Transmit capture and odd-parity check.
		always_comb begin
			txw_nxt = txw_r;
			txerr_nxt = txerr_r;
			tx_ones = ^{tx_word_in[c].data, tx_word_in[c].odd_parity};
			if (parity_control == LVL_HIGH || bypassed) begin
				tx_ones = tx_ones ^ (^tx_word_in[c].char_type);
			end
			if (tx_capture_en) begin
				txw_nxt = tx_word_in[c];
				txerr_nxt = (parity_control != LVL_LOW) && !tx_ones;
			end
		end

		// Receive output register and odd-parity generation.
		always_comb begin
			rxw_nxt = rxw_r;
			rxpar_nxt = rxpar_r;
			rx_ones = ^rx_word_in[c].data;
			if (parity_control == LVL_HIGH) begin
				rx_ones = rx_ones ^ (^rx_word_in[c].status);
			end else if (bypassed) begin
				rx_ones = rx_ones ^ (^rx_word_in[c].status[1:0]);
			end
			if (rx_word_valid[c] && (!rx_on_ref || ref_tick)) begin
				rxw_nxt = rx_word_in[c];
				rxpar_nxt = ~rx_ones;
			end
		end

		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				eb_char_r <= '0;
				eb_valid_r <= 1'b0;
				hold_r <= '0;
				hold_full_r <= 1'b0;
				ins_pend_r <= 1'b0;
				del_pend_r <= 1'b0;
				insert_now_r <= 1'b0;
				txw_r <= '0;
				txerr_r <= 1'b0;
				rxw_r <= '0;
				rxpar_r <= 1'b1;
			end else begin
				eb_char_r <= eb_char_nxt;
				eb_valid_r <= eb_valid_nxt;
				hold_r <= hold_nxt;
				hold_full_r <= hold_full_nxt;
				ins_pend_r <= ins_pend_nxt;
				del_pend_r <= del_pend_nxt;
				insert_now_r <= insert_now_nxt;
				txw_r <= txw_nxt;
				txerr_r <= txerr_nxt;
				rxw_r <= rxw_nxt;
				rxpar_r <= rxpar_nxt;
			end
		end

		assign rx_aligned_char[c] = eb_char_r;
		assign rx_aligned_valid[c] = eb_valid_r;
		assign tx_word_captured[c] = txw_r;
		assign tx_parity_error[c] = txerr_r;
		assign rx_word_out[c] = rxw_r;
		assign rx_odd_parity_out[c] = rxpar_r;
		assign rx_odd_parity_oe[c] = (parity_control != LVL_LOW);
	end

endmodule

// ### verif/xcvr_cfg_props.sv
// Checker for capture, parity, output enables and reference delay, watching channel 0.
// Assumes it is bound to rx_framer_parity_clock_select and sees only its ports.
`timescale 1ns/1ps
module xcvr_cfg_props
	import xcvr_cfg_pkg::*;
#(
	parameter int CHANNELS = NUM_CH
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire tri_level_t parity_control,
	input wire tri_level_t tx_operating_select,
	input wire tri_level_t decoder_select,
	input wire tri_level_t tx_clock_source_select,
	input wire tri_level_t rx_clock_source_select,
	input wire logic reference_clock,
	input wire logic ref_tick,
	input wire logic tx_clk_tick,
	input wire tx_word_t [CHANNELS-1:0] tx_word_in,
	input wire tx_word_t [CHANNELS-1:0] tx_word_captured,
	input wire logic [CHANNELS-1:0] tx_parity_error,
	input wire logic [CHANNELS-1:0] rx_bits_valid,
	input wire logic [CHANNELS-1:0] rx_aligned_valid,
	input wire logic [CHANNELS-1:0] rx_word_valid,
	input wire rx_word_t [CHANNELS-1:0] rx_word_in,
	input wire rx_word_t [CHANNELS-1:0] rx_word_out,
	input wire logic [CHANNELS-1:0] rx_odd_parity_out,
	input wire logic [CHANNELS-1:0] rx_odd_parity_oe,
	input wire logic delayed_reference_out,
	input wire logic delayed_reference_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic byp, tx_odd, rx_odd, rx_take;
	assign byp = tx_operating_select == LVL_LOW && decoder_select == LVL_LOW;
	assign tx_odd = (parity_control == LVL_HIGH || byp) ? ^tx_word_in[0]
		: ^{tx_word_in[0].data, tx_word_in[0].odd_parity};
	assign rx_odd = parity_control == LVL_HIGH ? ^rx_word_in[0]
		: byp ? ^{rx_word_in[0].status[1:0], rx_word_in[0].data} : ^rx_word_in[0].data;
	assign rx_take = rx_word_valid[0] && rx_clock_source_select != LVL_LOW;
	sequence s_tx_take;
		(tx_clock_source_select == LVL_LOW) ? ref_tick : tx_clk_tick;
	endsequence
	property p_tx_cap;
		s_tx_take |=> tx_word_captured[0] == $past(tx_word_in[0]);
	endproperty
	a_tx_cap: assert property (p_tx_cap) else $error("capture mismatch");
	property p_tx_keep;
		tx_clock_source_select == LVL_LOW && !ref_tick |=> $stable(tx_word_captured[0]);
	endproperty
	a_tx_keep: assert property (p_tx_keep) else $error("capture off reference");
	property p_tx_err;
		s_tx_take |=> tx_parity_error[0] == ($past(parity_control) != LVL_LOW && !$past(tx_odd));
	endproperty
	a_tx_err: assert property (p_tx_err) else $error("parity error flag wrong");
	property p_rx_par;
		rx_take && parity_control != LVL_LOW |=> rx_odd_parity_out[0] == !$past(rx_odd);
	endproperty
	a_rx_par: assert property (p_rx_par) else $error("receive parity wrong");
	property p_rx_word;
		rx_take |=> rx_word_out[0] == $past(rx_word_in[0]);
	endproperty
	a_rx_word: assert property (p_rx_word) else $error("receive word wrong");
	property p_par_oe;
		rx_odd_parity_oe[0] == (parity_control != LVL_LOW);
	endproperty
	a_par_oe: assert property (p_par_oe) else $error("parity enable wrong");
	property p_ref_oe;
		delayed_reference_oe == (rx_clock_source_select == LVL_LOW);
	endproperty
	a_ref_oe: assert property (p_ref_oe) else $error("reference enable wrong");
	property p_ref_dly;
		rx_clock_source_select == LVL_LOW |=> delayed_reference_out == $past(reference_clock);
	endproperty
	a_ref_dly: assert property (p_ref_dly) else $error("reference delay wrong");
	property p_align_src;
		rx_aligned_valid[0] && rx_clock_source_select != LVL_LOW |-> $past(rx_bits_valid[0], 2);
	endproperty
	a_align_src: assert property (p_align_src) else $error("stray aligned char");
endmodule
bind rx_framer_parity_clock_select xcvr_cfg_props #(.CHANNELS(CHANNELS)) i_xcvr_cfg_props (.*);

// ### verif/host_char_source.sv
// Host model: builds transmit characters with odd parity and picks the framing symbol.
// Assumes the bench gives it character content and a request to spoil parity.
`timescale 1ns/1ps
module host_char_source
	import xcvr_cfg_pkg::*;
(
	input wire logic [7:0] data,
	input wire logic [1:0] char_type,
	input wire logic corrupt,
	input wire logic want_full,
	output tx_word_t word,
	output tri_level_t symbol_sel
);
	// Parity spans the widest set, so a narrower check can see it as wrong on purpose.
	assign word = '{char_type: char_type, data: data, odd_parity: ~^{char_type, data} ^ corrupt};
	// The test-only low setting is never driven.
	assign symbol_sel = want_full ? LVL_HIGH : LVL_MID;
endmodule

// ### verif/rx_framer_parity_clock_select_test.sv
// Self-checking bench for framing, compensation, parity and clock selection.
// Assumes the host model drives transmit characters and the framing symbol select.
`timescale 1ns/1ps
module rx_framer_parity_clock_select_test;
	import xcvr_cfg_pkg::*;
	typedef struct {tri_level_t pc, tm, dm; logic [7:0] d; logic [1:0] ct; logic b;
		logic [7:0] rd; logic [2:0] st; logic terr, rpar;} prow_t;
	typedef struct {tri_level_t sty; logic alw, full; tri_level_t rxs;
		logic ins, del, hit; int cnt;} frow_t;
	localparam logic [9:0] SHIFTED = {K285_RD_NEG[2:0], K285_RD_NEG[9:3]};
	prow_t rows[8] = '{
		'{LVL_MID, LVL_MID, LVL_MID, 8'h01, 2'h1, 1'b0, 8'h03, 3'h7, 1'b1, 1'b1},
		'{LVL_MID, LVL_MID, LVL_MID, 8'h01, 2'h0, 1'b0, 8'h07, 3'h0, 1'b0, 1'b0},
		'{LVL_MID, LVL_LOW, LVL_LOW, 8'h01, 2'h1, 1'b0, 8'h01, 3'h1, 1'b0, 1'b1},
		'{LVL_MID, LVL_LOW, LVL_LOW, 8'h01, 2'h1, 1'b1, 8'h00, 3'h4, 1'b1, 1'b1},
		'{LVL_HIGH, LVL_MID, LVL_MID, 8'h00, 2'h3, 1'b0, 8'h00, 3'h4, 1'b0, 1'b0},
		'{LVL_HIGH, LVL_MID, LVL_MID, 8'hff, 2'h2, 1'b1, 8'hff, 3'h0, 1'b1, 1'b1},
		'{LVL_LOW, LVL_MID, LVL_MID, 8'h00, 2'h0, 1'b1, 8'h00, 3'h0, 1'b0, 1'b0},
		'{LVL_MID, LVL_LOW, LVL_MID, 8'h00, 2'h3, 1'b0, 8'h00, 3'h3, 1'b0, 1'b1}};
	frow_t f[6] = '{'{LVL_HIGH, 1, 1, LVL_MID, 0, 0, 1, 8}, '{LVL_MID, 1, 0, LVL_MID, 0, 0, 1, 8},
		'{LVL_LOW, 1, 1, LVL_MID, 0, 0, 1, 8}, '{LVL_HIGH, 0, 1, LVL_MID, 0, 0, 0, 8},
		'{LVL_HIGH, 1, 1, LVL_LOW, 1, 0, 1, 9}, '{LVL_HIGH, 1, 1, LVL_LOW, 0, 1, 1, 7}};
	logic sys_clk, rst, reframe_allow, reference_clock, ref_tick, tx_clk_tick, want_full, bad;
	tri_level_t framer_style_select, frame_symbol_select, parity_control, tx_operating_select;
	tri_level_t decoder_select, tx_clock_source_select, rx_clock_source_select;
	tx_word_t [1:0] tx_word_in, tx_word_captured;
	tx_word_t host_word;
	rx_word_t [1:0] rx_word_in, rx_word_out;
	logic [1:0] tx_parity_error, rx_bits_valid, rx_aligned_valid, comp_insert_req, comp_delete_req;
	logic [1:0] rx_word_valid, rx_odd_parity_out, rx_odd_parity_oe;
	logic [1:0][9:0] rx_bits_in, rx_aligned_char;
	logic delayed_reference_out, delayed_reference_oe;
	logic [7:0] data;
	logic [1:0] ct;
	int failures, n_checks, nval;
	rx_framer_parity_clock_select i_rx_framer_parity_clock_select (.*);
	host_char_source i_host_char_source (.data(data), .char_type(ct), .corrupt(bad),
		.want_full(want_full), .word(host_word), .symbol_sel(frame_symbol_select));
	assign tx_word_in = {2{host_word}};
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) reference_clock <= ~reference_clock;
	task automatic step();
		@(negedge sys_clk);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			failures++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
		end
	endtask
	// Each character is followed by idle cycles so a held character can drain.
	task automatic feed(input int n);
		for (int k = 0; k < n; k++) begin
			rx_bits_in = {2{SHIFTED}};
			rx_bits_valid = 2'b11;
			step();
			nval += rx_aligned_valid[0];
			rx_bits_valid = 2'b00;
			repeat (3) begin
				step();
				nval += rx_aligned_valid[0];
			end
		end
	endtask
	task automatic give_verdict();
		if (failures == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		#(25ns * 5000);
		failures++;
		give_verdict();
	end
	initial begin
		{rst, reframe_allow, reference_clock, ref_tick, tx_clk_tick, want_full, bad} = 7'h61;
		framer_style_select = LVL_HIGH;
		parity_control = LVL_LOW;
		tx_operating_select = LVL_MID;
		decoder_select = LVL_MID;
		tx_clock_source_select = LVL_MID;
		rx_clock_source_select = LVL_MID;
		{data, ct, rx_bits_valid, rx_bits_in, comp_insert_req, comp_delete_req} = '0;
		rx_word_valid = 2'b00;
		rx_word_in = '0;
		repeat (16) step();
		check(rx_odd_parity_oe, 2'b00);
		check(tx_parity_error, 2'b00);
		rst = 1'b0;
		for (int i = 0; i < 8; i++) begin
			parity_control = rows[i].pc;
			tx_operating_select = rows[i].tm;
			decoder_select = rows[i].dm;
			{data, ct, bad} = {rows[i].d, rows[i].ct, rows[i].b};
			rx_word_in = {2{rx_word_t'{rows[i].st, rows[i].rd}}};
			{tx_clk_tick, rx_word_valid} = 3'h7;
			step();
			{tx_clk_tick, rx_word_valid} = 3'h0;
			check(tx_parity_error[0], rows[i].terr);
			check(rx_odd_parity_oe[0], rows[i].pc != LVL_LOW);
			if (rows[i].pc != LVL_LOW) check(rx_odd_parity_out[0], rows[i].rpar);
		end
		// A reset before each framing case clears the learnt character offset.
		for (int c = 0; c < 6; c++) begin
			rst = 1'b1;
			framer_style_select = f[c].sty;
			{reframe_allow, want_full} = {f[c].alw, f[c].full};
			rx_clock_source_select = f[c].rxs;
			step();
			rst = 1'b0;
			feed(8);
			{comp_insert_req, comp_delete_req} = {{2{f[c].ins}}, {2{f[c].del}}};
			step();
			{comp_insert_req, comp_delete_req} = 4'h0;
			nval = 0;
			feed(8);
			check(rx_aligned_char[0] === K285_RD_NEG, f[c].hit);
			check(nval, f[c].cnt);
			check(delayed_reference_oe, f[c].rxs == LVL_LOW);
		end
		tx_clock_source_select = LVL_LOW;
		data = 8'h5a;
		tx_clk_tick = 1'b1;
		step();
		tx_clk_tick = 1'b0;
		check(tx_word_captured[0], 11'h0);
		ref_tick = 1'b1;
		step();
		ref_tick = 1'b0;
		check(tx_word_captured[0], host_word);
		give_verdict();
	end
endmodule
